// ### src/csm_softmixer.sv
// Purpose: Component input path: matrix, picture control, key-driven
//          coefficient and 4:4:4 soft-mix with the main picture.
// Assumes: CLK at 125 MHz; main samples arrive with valid/ready at the
//          system sample rate; component and key codes come from ADCs.
// Notes:   Main picture paces everything; a two-entry output buffer
//          absorbs receiver stalls without losing a sample.
module csm_softmixer
  import csm_pkg::*;
#(
  parameter int GAIN_W = 4                      // Width of mix gain
)
(
  input  wire logic                CLK,                     // 125 MHz clock
  input  wire logic                RESETN,                  // Async reset, active low
  input  wire csm_comp_type        COMP_A_PIXEL,            // Keyed component port
  input  wire csm_comp_type        COMP_B_PIXEL,            // Unkeyed component port
  input  wire logic [5:0]          INSERT_KEY_LEVEL,        // Digitised fast-blank key
  input  wire logic                PORT_SELECT,             // 0 port A, 1 port B
  input  wire logic                SOURCE_IS_RGB,           // 1 RGB, 0 Y/Cr/Cb
  input  wire logic [5:0]          CONTRAST,                // Luma gain, 1/32 steps
  input  wire logic signed [7:0]   BRIGHTNESS,              // Luma offset
  input  wire logic [5:0]          RED_DIFF_GAIN,           // Cr gain, 1/32 steps
  input  wire logic [5:0]          BLUE_DIFF_GAIN,          // Cb gain, 1/32 steps
  input  wire logic signed [5:0]   TINT,                    // Degrees, -20..20
  input  wire logic [GAIN_W-1:0]   MIX_GAIN,                // Coefficient gain
  input  wire logic [5:0]          MIX_OFFSET,              // Coefficient key offset
  input  wire logic                NONLINEAR_SELECT,        // Nonlinear key shaping
  input  wire logic                COMPONENT_DELAY_SELECT,  // Extra sample of key delay
  input  wire logic                COEFFICIENT_CLAMP,       // Static mix when keyed mode
  input  wire logic [1:0]          BLANK_MODE_SELECT,       // Mixer mode
  input  wire logic                MAIN_VALID,              // Main sample offered
  input  wire csm_pixel_type       MAIN_PIXEL,              // Upsampled main picture
  output logic                     MAIN_READY,              // Main sample taken
  output logic                     MIX_VALID,               // Mixed sample offered
  output csm_pixel_type            MIX_PIXEL,               // Mixed 4:4:4 picture
  input  wire logic                MIX_READY                // Receiver takes sample
);

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------

  // Limit an integer to a range
  function automatic int clamp_int(input int v, input int lo, input int hi);
    if (v < lo)
    begin
      return lo;
    end
    if (v > hi)
    begin
      return hi;
    end
    return v;
  endfunction

  // Saturate a coefficient into 0..64
  function automatic logic [6:0] coeff_sat(input int v);
    return 7'(clamp_int(v, 0, K_FULL)); // R16
  endfunction

  // Linear coefficient from gain, key and offset, saturated
  function automatic logic [6:0] coeff_linear(input int g, input int kv, input int o);
    return coeff_sat(g * (kv - o) + K_HALF); // R15 R18
  endfunction

  // Monotonic reshaping of the linear coefficient
  function automatic logic [6:0] coeff_nonlinear(input logic [6:0] k);
    int kv;
    kv = int'(k);
    if (kv <= NL_LOW)
    begin
      return 7'h00; // R21
    end
    if (kv >= NL_HIGH)
    begin
      return 7'(K_FULL); // R21
    end
    // Straight ramp between the knees
    return coeff_sat((kv - NL_LOW) * NL_SLOPE); // R19 R21
  endfunction

  // RGB to luma and colour differences, or pass-through
  function automatic csm_ycc_type to_ycc(input csm_comp_type c, input logic rgb);
    csm_ycc_type o;
    int          r;
    int          g;
    int          b;
    r = int'(c.ch0);
    g = int'(c.ch1);
    b = int'(c.ch2);
    if (rgb)
    begin
      // Fixed matrix, rounded to nearest
      o.y  = 8'(clamp_int((MTX_Y_R * r + MTX_Y_G * g + MTX_Y_B * b + MTX_ROUND)
                          >>> MTX_SHIFT, 0, PIX_MAX)); // R01
      o.cr = 10'((MTX_CR_R * r - MTX_Y_G * g - MTX_Y_B * b + MTX_ROUND)
                 >>> MTX_SHIFT); // R02
      o.cb = 10'((MTX_CB_B * b - MTX_Y_R * r - MTX_Y_G * g + MTX_ROUND)
                 >>> MTX_SHIFT); // R02
    end
    else
    begin
      // Already luma and differences: only remove the chroma offset
      o.y  = c.ch0; // R03
      o.cr = 10'(g - CHROMA_MID); // R03
      o.cb = 10'(b - CHROMA_MID); // R03
    end
    return o;
  endfunction

  // Contrast, brightness, colour gains and tint
  function automatic csm_pixel_type picture_ctl(
    input csm_ycc_type        i,
    input logic [5:0]         con,
    input logic signed [7:0]  bri,
    input logic [5:0]         rg,
    input logic [5:0]         bg,
    input logic signed [5:0]  tin
  );
    csm_pixel_type o;
    int            y;
    int            cr;
    int            cb;
    int            t;
    int            sn;
    int            cs;
    int            crr;
    int            cbr;
    y  = ((int'(i.y) * int'(con) + GAIN_ROUND) >>> GAIN_SHIFT) + int'(bri); // R04
    cr = (int'(i.cr) * int'(rg)) >>> GAIN_SHIFT; // R05
    cb = (int'(i.cb) * int'(bg)) >>> GAIN_SHIFT; // R05
    // Small-angle sine and cosine keep the rotation cheap
    t   = clamp_int(int'(tin), -TINT_MAX, TINT_MAX); // R06
    sn  = t * TINT_SIN_K;
    cs  = TINT_ONE - ((t * t * TINT_COS_K) >>> TINT_COS_SH);
    crr = (cr * cs - cb * sn) >>> TINT_SHIFT; // R06
    cbr = (cb * cs + cr * sn) >>> TINT_SHIFT; // R06
    // Saturate back to offset-binary codes
    o.y  = 8'(clamp_int(y, 0, PIX_MAX));
    o.cr = 8'(clamp_int(crr + CHROMA_MID, 0, PIX_MAX));
    o.cb = 8'(clamp_int(cbr + CHROMA_MID, 0, PIX_MAX));
    return o;
  endfunction

  // Weighted blend of one channel
  function automatic logic [7:0] mix_ch(input logic [7:0] m, input logic [7:0] c,
                                        input logic [6:0] k);
    int kv;
    kv = int'(k);
    return 8'((kv * int'(m) + (K_FULL - kv) * int'(c) + K_HALF) >>> K_SHIFT); // R13
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  csm_state_type s;       // Registered state
  csm_state_type next_s;  // Next state

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb
  begin
    csm_comp_type  comp;    // Selected component sample
    int            key;     // Key of the selected port
    int            gain;    // Coefficient gain
    int            offs;    // Coefficient offset
    logic [6:0]    k_new;   // Coefficient of this sample
    logic          accept;  // Main sample taken this cycle
    logic          pop;     // Receiver takes head
    csm_pixel_type mixed;   // Blended pixel leaving stage 2
    int            occ;     // Samples in flight after this cycle
    comp   = '0;
    key    = 0;
    gain   = 0;
    offs   = 0;
    k_new  = '0;
    accept = 1'b0;
    pop    = 1'b0;
    mixed  = '0;
    occ    = 0;
    next_s = s;

    // Pin samples pass two flip-flops before use
    next_s.comp_a_s1 = COMP_A_PIXEL; // R08
    next_s.comp_a_s2 = s.comp_a_s1;
    next_s.comp_b_s1 = COMP_B_PIXEL; // R08
    next_s.comp_b_s2 = s.comp_b_s1;
    next_s.key_s1    = INSERT_KEY_LEVEL; // R09
    next_s.key_s2    = s.key_s1;

    // Port A carries the key; port B reads as no key
    comp = PORT_SELECT ? s.comp_b_s2 : s.comp_a_s2; // R10
    key  = PORT_SELECT ? 0 : int'(s.key_s2); // R10

    // Coefficient from mode decode
    gain = int'(MIX_GAIN);
    offs = int'(MIX_OFFSET);
    if (!BLANK_MODE_SELECT[0])
    begin
      // Component picture only
      k_new = 7'h00; // R14 R20
    end
    else if (BLANK_MODE_SELECT == BLANK_FORCE_MAIN)
    begin
      // Main picture only
      k_new = 7'(K_FULL); // R14 R20
    end
    else if (COEFFICIENT_CLAMP)
    begin
      // Key is not looked at here
      k_new = coeff_linear(gain, STATIC_KEY, offs); // R15 R17 R20
    end
    else
    begin
      // Live key, optionally reshaped
      k_new = coeff_linear(gain, key, offs); // R18 R20
      if (NONLINEAR_SELECT)
      begin
        k_new = coeff_nonlinear(k_new); // R19 R20
      end
    end

    // Stage 1: each main sample fetches the current component sample
    accept   = MAIN_VALID && s.ready; // R11
    next_s.v1 = accept;
    if (accept)
    begin
      next_s.main1  = MAIN_PIXEL; // R12
      next_s.ycc1   = to_ycc(comp, SOURCE_IS_RGB);
      // Kept for the next sample when the key is held back
      next_s.k_prev = k_new;
      // Delay select holds the key back by one sample
      next_s.k1     = COMPONENT_DELAY_SELECT ? s.k_prev : k_new; // R20
    end

    // Stage 2: picture control, main carried alongside
    next_s.v2 = s.v1;
    if (s.v1)
    begin
      // Live picture settings act on this sample
      next_s.main2 = s.main1; // R12
      next_s.comp2 = picture_ctl(s.ycc1, CONTRAST, BRIGHTNESS, RED_DIFF_GAIN,
                                 BLUE_DIFF_GAIN, TINT); // R22
      next_s.k2    = s.k1;
    end

    // Mix and push into the two-entry buffer
    mixed.y  = mix_ch(s.main2.y, s.comp2.y, s.k2); // R13
    mixed.cr = mix_ch(s.main2.cr, s.comp2.cr, s.k2); // R13
    mixed.cb = mix_ch(s.main2.cb, s.comp2.cb, s.k2); // R13
    // Receiver takes the head this cycle
    pop = s.head_v && MIX_READY;
    if (pop)
    begin
      // Tail moves up into the head
      next_s.head   = s.tail;
      next_s.head_v = s.tail_v;
      next_s.tail_v = 1'b0;
    end
    // Fill the head first, else the tail
    if (s.v2)
    begin
      if (!next_s.head_v)
      begin
        next_s.head   = mixed; // R12
        next_s.head_v = 1'b1;
      end
      else
      begin
        next_s.tail   = mixed; // R12
        next_s.tail_v = 1'b1;
      end
    end

    // Admit a new sample only when the buffer is sure to have room
    occ = int'(next_s.v1) + int'(next_s.v2) + int'(next_s.head_v)
        + int'(next_s.tail_v);
    next_s.ready = (occ < OCC_LIMIT);
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      // Whole state to its reset value
      s <= STATE_RESET;
    end
    else
    begin
      // Advance every stage
      s <= next_s;
    end
  end

  // ----------------------------------------------------------------
  // Outputs, all straight from state
  // ----------------------------------------------------------------
  assign MAIN_READY = s.ready;
  assign MIX_VALID  = s.head_v;
  assign MIX_PIXEL  = s.head;

endmodule

// ### src/csm_pkg.sv
// What this block does
// R01: RGB luma is 0.299R+0.587G+0.114B
// R02: Colour differences from fixed RGB matrix
// R03: Luma/colour-difference source bypasses the matrix
// R04: Contrast 0..63/32, brightness -128..127
// R05: Separate red/blue difference gains 0..63/32
// R06: Tint rotation between -20 and +20 degrees
// R07: Controller programs level-matching picture settings
// R08: Three 8-bit component channels per sample
// R09: Fast-blank key digitised at 6 bits
// R10: Two component ports, only first keyed
// R11: Sample timing always follows main picture
// R12: Delay-match, merge into one 4:4:4 stream
// R13: Output is (k*main+(64-k)*comp)/64
// R14: Static switch forces k to 0 or 64
// R15: Static mix k=gain*(31-offset)+32
// R16: Every k rounded, saturated to 0..64
// R17: Static modes ignore the fast-blank key
// R18: Linear k=gain*(key-offset)+32 per sample
// R19: Nonlinear mode reshapes linear k
// R20: Mode decode from mode, clamp, nonlinear bits
// R21: Nonlinear shape is a monotonic mapping
// R22: Settings act from the next sample
//
// Purpose: Constants and carrier types of the component soft-mixer.
// Assumes: 8-bit offset-binary pixels, 6-bit fast-blank key.
// Notes:   Fixed-point matrix uses a 1024 scale.
package csm_pkg;

  // ----------------------------------------------------------------
  // Arithmetic constants
  // ----------------------------------------------------------------
  localparam int PIX_MAX      = 255;   // Largest pixel code
  localparam int CHROMA_MID   = 128;   // Offset of colour-difference codes
  localparam int MTX_SHIFT    = 10;    // Matrix fraction bits
  localparam int MTX_ROUND    = 512;   // Half of matrix scale
  localparam int MTX_Y_R      = 306;   // 0.299 scaled
  localparam int MTX_Y_G      = 601;   // 0.587 scaled
  localparam int MTX_Y_B      = 117;   // 0.114 scaled
  localparam int MTX_CR_R     = 718;   // 0.701 scaled
  localparam int MTX_CB_B     = 907;   // 0.886 scaled
  localparam int GAIN_SHIFT   = 5;     // Gains are in 1/32 steps
  localparam int GAIN_ROUND   = 16;    // Half of gain step
  localparam int TINT_MAX     = 20;    // Tint limit in degrees
  localparam int TINT_SIN_K   = 18;    // Radians per degree, 1024 scale
  localparam int TINT_ONE     = 1024;  // Unity in tint arithmetic
  localparam int TINT_SHIFT   = 10;    // Tint fraction bits
  localparam int TINT_COS_K   = 324;   // Square of TINT_SIN_K
  localparam int TINT_COS_SH  = 11;    // Halves and rescales the square term
  localparam int K_FULL       = 64;    // Coefficient for pure main picture
  localparam int K_HALF       = 32;    // Coefficient centre
  localparam int K_SHIFT      = 6;     // Divide by 64
  localparam int STATIC_KEY   = 31;    // Fixed key used by static mixing
  localparam int NL_LOW       = 16;    // Nonlinear knee, low end
  localparam int NL_HIGH      = 48;    // Nonlinear knee, high end
  localparam int NL_SLOPE     = 2;     // Slope between the knees
  localparam int OCC_LIMIT    = 2;     // Samples in flight plus buffered

  // Mode codes on the blank mode selector
  localparam logic [1:0] BLANK_FORCE_MAIN = 2'h3;
  localparam logic [1:0] BLANK_KEYED      = 2'h1;

  // ----------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------
  // Raw component sample: R,G,B or Y,Cr,Cb in channel order
  typedef struct packed {
    logic [7:0] ch0;
    logic [7:0] ch1;
    logic [7:0] ch2;
  } csm_comp_type;

  // Offset-binary 4:4:4 pixel
  typedef struct packed {
    logic [7:0] y;
    logic [7:0] cr;
    logic [7:0] cb;
  } csm_pixel_type;

  // Luma with signed colour differences
  typedef struct packed {
    logic        [7:0] y;
    logic signed [9:0] cr;
    logic signed [9:0] cb;
  } csm_ycc_type;

  // Whole state of the soft-mixer
  typedef struct packed {
    csm_comp_type  comp_a_s1;
    csm_comp_type  comp_a_s2;
    csm_comp_type  comp_b_s1;
    csm_comp_type  comp_b_s2;
    logic [5:0]    key_s1;
    logic [5:0]    key_s2;
    logic          v1;
    csm_pixel_type main1;
    csm_ycc_type   ycc1;
    logic [6:0]    k1;
    logic [6:0]    k_prev;
    logic          v2;
    csm_pixel_type main2;
    csm_pixel_type comp2;
    logic [6:0]    k2;
    csm_pixel_type head;
    logic          head_v;
    csm_pixel_type tail;
    logic          tail_v;
    logic          ready;
  } csm_state_type;

  localparam csm_state_type STATE_RESET = '0;

endpackage

// ### test/csm_main_src.sv
// Purpose: Main-picture source model offering queued samples.
// Assumes: A sample is held until ready is seen at a rising edge.
// Notes:   Pixel lines toggle while nothing is offered.
module csm_main_src
  import csm_pkg::*;
(
  input  wire logic     clk,    // Sample clock
  input  wire logic     rst_n,  // Reset, active low
  input  wire logic     ready,  // Sample taken
  output logic          valid,  // Sample offered
  output csm_pixel_type pixel   // Offered sample
);
  timeunit 1ns;
  timeprecision 1ps;
  csm_pixel_type q[$];  // Samples waiting to be offered
  initial
  begin
    valid = 1'b0;
    pixel = '0;
  end
  // Pop the head once taken, then offer the next or toggle
  always @(posedge clk)
  begin
    if (valid && ready)
      void'(q.pop_front());
    if (rst_n && q.size() > 0)
    begin
      valid <= 1'b1;
      pixel <= q[0];
    end
    else
    begin
      valid <= 1'b0;
      pixel <= ~pixel;
    end
  end
endmodule

// ### test/csm_softmixer_sva.sv
// Purpose: Port-level checks of the component soft-mixer.
// Assumes: Occupancy is counted from the two handshakes.
// Notes:   Latency figures hold with a free receiver.
module csm_softmixer_sva
  import csm_pkg::*;
(
  input  wire logic          CLK,
  input  wire logic          RESETN,
  input  wire logic [1:0]    BLANK_MODE_SELECT,
  input  wire logic          MAIN_VALID,
  input  wire csm_pixel_type MAIN_PIXEL,
  input  wire logic          MAIN_READY,
  input  wire logic          MIX_VALID,
  input  wire csm_pixel_type MIX_PIXEL,
  input  wire logic          MIX_READY
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       take_in;   // Main sample taken
  logic       take_out;  // Mixed sample taken
  logic [2:0] occ;       // Samples in flight or buffered
  assign take_in  = MAIN_VALID && MAIN_READY;
  assign take_out = MIX_VALID && MIX_READY;
  // Occupancy tracks takes in minus takes out
  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
      occ <= 3'h0;
    else
      occ <= occ + 3'(take_in) - 3'(take_out);
  end
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RESETN);
  // Main picture forced, receiver free, mode held
  sequence main_take_s;
    take_in && MIX_READY && BLANK_MODE_SELECT == BLANK_FORCE_MAIN
    ##1 (MIX_READY && BLANK_MODE_SELECT == BLANK_FORCE_MAIN)[*3];
  endsequence
  chk_mix_hold: assert property (MIX_VALID && !MIX_READY |=> MIX_VALID && $stable(MIX_PIXEL))
    else $error("stalled sample lost or changed");
  chk_occ_bound: assert property (int'(occ) <= OCC_LIMIT)
    else $error("more samples held than buffered");
  chk_ready_full: assert property (int'(occ) == OCC_LIMIT |-> !MAIN_READY)
    else $error("ready while full");
  chk_ready_idle: assert property (RESETN && occ == 3'h0 |=> MAIN_READY)
    else $error("not ready while empty");
  chk_ready_back: assert property (int'(occ) == OCC_LIMIT && take_out |=> MAIN_READY)
    else $error("ready not restored after drain");
  chk_valid_cause: assert property (MIX_VALID |-> occ != 3'h0)
    else $error("output without a sample");
  chk_rise_latency: assert property ($rose(MIX_VALID) |-> $past(take_in, 3))
    else $error("output latency not three");
  chk_force_main: assert property (main_take_s |-> MIX_VALID && MIX_PIXEL == $past(MAIN_PIXEL, 3))
    else $error("forced main picture altered");
  cover property (int'(occ) == OCC_LIMIT && !MIX_READY);
  cover property (main_take_s);
  cover property ($rose(MIX_VALID));
endmodule

bind csm_softmixer csm_softmixer_sva csm_softmixer_sva_inst (
  .CLK (CLK), .RESETN (RESETN), .BLANK_MODE_SELECT (BLANK_MODE_SELECT),
  .MAIN_VALID (MAIN_VALID), .MAIN_PIXEL (MAIN_PIXEL), .MAIN_READY (MAIN_READY),
  .MIX_VALID (MIX_VALID), .MIX_PIXEL (MIX_PIXEL), .MIX_READY (MIX_READY)
);

// ### test/tb.sv
// Purpose: Self-checking bench of the component soft-mixer.
// Assumes: Receiver ready except in the stall case.
// Notes:   Expected pixels are worked out here from the mix formula.
module tb
  import csm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic              CLK, RESETN, port_sel, rgb, nl, dly, clamp;
  csm_comp_type      comp_a, comp_b;      // Component port samples
  logic [5:0]        key, con, rdg, bdg, offs;
  logic signed [7:0] bri;                 // Brightness
  logic signed [5:0] tint;                // Tint in degrees
  logic [3:0]        gain;                // Mix gain
  logic [1:0]        mode;                // Mixer mode
  logic              main_valid, main_ready, mix_valid, mix_ready;
  csm_pixel_type     main_pixel, mix_pixel;
  int                errors, samples_checked;
  csm_pixel_type     main_px = 24'hc83c5a;  // Main picture sample
  csm_comp_type      comp_y  = 24'h28aa96;  // Passes unity settings unchanged

  initial
  begin
    CLK = 1'b0;
    forever #4 CLK = ~CLK;
  end

  csm_main_src csm_main_src_inst (.clk (CLK), .rst_n (RESETN), .ready (main_ready),
    .valid (main_valid), .pixel (main_pixel));
  csm_softmixer csm_softmixer_inst (.CLK (CLK), .RESETN (RESETN),
    .COMP_A_PIXEL (comp_a), .COMP_B_PIXEL (comp_b), .INSERT_KEY_LEVEL (key),
    .PORT_SELECT (port_sel), .SOURCE_IS_RGB (rgb), .CONTRAST (con), .BRIGHTNESS (bri),
    .RED_DIFF_GAIN (rdg), .BLUE_DIFF_GAIN (bdg), .TINT (tint), .MIX_GAIN (gain),
    .MIX_OFFSET (offs), .NONLINEAR_SELECT (nl), .COMPONENT_DELAY_SELECT (dly),
    .COEFFICIENT_CLAMP (clamp), .BLANK_MODE_SELECT (mode), .MAIN_VALID (main_valid),
    .MAIN_PIXEL (main_pixel), .MAIN_READY (main_ready), .MIX_VALID (mix_valid),
    .MIX_PIXEL (mix_pixel), .MIX_READY (mix_ready));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic complete_run();
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Weighted mix per channel with rounding
  function automatic csm_pixel_type mix(int k, csm_pixel_type m, csm_pixel_type c);
    mix.y  = 8'((k * m.y + (64 - k) * c.y + 32) >> 6);
    mix.cr = 8'((k * m.cr + (64 - k) * c.cr + 32) >> 6);
    mix.cb = 8'((k * m.cb + (64 - k) * c.cb + 32) >> 6);
  endfunction
  task automatic wait_out(output csm_pixel_type got);
    int n;
    n = 0;
    do
    begin
      @(posedge CLK);
      #1;
      n++;
    end
    while (mix_valid !== 1'b1 && n < 60);
    if (n >= 60)
    begin
      errors++;
      complete_run();
    end
    got = mix_pixel;
  endtask
  // Hold component and key, let them sync, send one main sample
  task automatic go(csm_comp_type c, logic [5:0] kv, int k, csm_pixel_type e);
    csm_pixel_type got;
    @(posedge CLK);
    comp_a <= c;
    key    <= kv;
    repeat (3) @(posedge CLK);
    csm_main_src_inst.q.push_back(main_px);
    wait_out(got);
    if (k >= 0)
      check("mix pixel", 32'(got), 32'(mix(k, main_px, e)));
  endtask
  // Row: mode, clamp, nonlinear, delay, gain, offset, key, k
  task automatic row(int r[8]);
    @(posedge CLK);
    mode  <= 2'(r[0]);
    clamp <= 1'(r[1]);
    nl    <= 1'(r[2]);
    dly   <= 1'(r[3]);
    gain  <= 4'(r[4]);
    offs  <= 6'(r[5]);
    go(comp_y, 6'(r[6]), r[7], comp_y);
  endtask
  task automatic pic(logic r, int c, int b, int g1, int g2, int t);
    @(posedge CLK);
    rgb  <= r;
    con  <= 6'(c);
    bri  <= 8'(b);
    rdg  <= 6'(g1);
    bdg  <= 6'(g2);
    tint <= 6'(t);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_static();
    int rows[8][8] = '{'{3,0,0,0,0,0,0,64}, '{0,0,0,0,0,0,63,0}, '{2,1,0,0,0,0,63,0},
      '{1,1,0,0,1,31,0,32}, '{1,1,0,0,1,31,63,32}, '{1,1,0,0,1,30,5,33},
      '{1,1,0,0,15,0,0,64}, '{1,1,0,0,15,63,63,0}};
    foreach (rows[i]) row(rows[i]);
  endtask
  task automatic t_keyed();
    int rows[8][8] = '{'{1,0,0,0,2,20,20,32}, '{1,0,0,0,2,20,30,52},
      '{1,0,0,0,2,20,63,64}, '{1,0,0,0,2,20,0,0}, '{1,0,1,0,2,20,30,64},
      '{1,0,1,0,2,20,26,56}, '{1,0,1,0,2,20,14,8}, '{1,0,1,0,2,20,12,0}};
    foreach (rows[i]) row(rows[i]);
  endtask
  task automatic t_delay();
    int rows[2][8] = '{'{1,0,1,1,2,20,30,-1}, '{1,0,1,1,2,20,12,64}};
    foreach (rows[i]) row(rows[i]);
  endtask
  task automatic t_rgb();
    pic(1'b1, 32, 0, 32, 32, 0);
    mode <= 2'h0;
    go(24'h646464, 6'h00, 0, 24'h648080);
    pic(1'b1, 32, 0, 16, 32, 0);
    go(24'hc80000, 6'h00, 0, 24'h3cc644);
  endtask
  task automatic t_picture();
    pic(1'b0, 63, -128, 32, 32, 0);
    go(24'h648080, 6'h00, 0, 24'h458080);
    pic(1'b0, 32, 0, 32, 32, 20);
    go(24'h6480c0, 6'h00, 0, 24'h6469bc);
    pic(1'b0, 27, 68, 40, 40, 0);
    go(24'h648080, 6'h00, 0, 24'h988080);
    pic(1'b0, 32, 0, 32, 32, 0);
  endtask
  task automatic t_port();
    row('{1,0,0,0,2,0,0,-1});
    @(posedge CLK);
    port_sel <= 1'b1;
    comp_b   <= 24'h506070;
    go(comp_y, 6'h3f, 32, 24'h506070);
    @(posedge CLK);
    port_sel <= 1'b0;
  endtask
  task automatic t_stall();
    csm_pixel_type got;
    @(posedge CLK);
    mode      <= 2'h3;
    mix_ready <= 1'b0;
    for (int i = 0; i < 3; i++)
      csm_main_src_inst.q.push_back(24'h102030 + 24'(i));
    repeat (12) @(posedge CLK);
    #1;
    check("ready while full", 32'(main_ready), 32'h0);
    check("held head", 32'({mix_valid, mix_pixel}), 32'h01102030);
    @(posedge CLK);
    mix_ready <= 1'b1;
    for (int i = 1; i < 3; i++)
    begin
      wait_out(got);
      check("drain order", 32'(got), 32'h102030 + 32'(i));
    end
  endtask

  // Reset, then run every scenario
  initial
  begin
    errors = 0;
    samples_checked = 0;
    RESETN = 1'b0;
    {comp_a, comp_b, key, port_sel, rgb, bri, tint} = '0;
    {gain, offs, nl, dly, clamp, mode} = '0;
    {con, rdg, bdg} = {6'h20, 6'h20, 6'h20};
    mix_ready = 1'b1;
    repeat (16) @(posedge CLK);
    RESETN <= 1'b1;
    repeat (2) @(posedge CLK);
    t_static();
    t_keyed();
    t_delay();
    t_rgb();
    t_picture();
    t_port();
    t_stall();
    complete_run();
  end
endmodule
